// ==== verilog/ife_pkg.sv ====
// package: field positions, widths and carrier structs of the instruction field extractor
`default_nettype none
package ife_pkg;

  localparam int unsigned WORD_W = 32;

  // field positions, numbered from the most significant bit
  localparam int unsigned POS_PRIMARY   = 0;
  localparam int unsigned W_PRIMARY     = 6;
  localparam int unsigned POS_SEC_PLAIN = 21;
  localparam int unsigned W_SEC_PLAIN   = 10;
  localparam int unsigned POS_SEC_OVF   = 22;
  localparam int unsigned W_SEC_OVF     = 9;
  localparam int unsigned POS_OVF_EN    = 21;
  localparam int unsigned POS_RECORD    = 31;
  localparam int unsigned POS_LINK      = 31;
  localparam int unsigned POS_ABS       = 30;
  localparam int unsigned POS_FIELD_A   = 6;
  localparam int unsigned POS_FIELD_B   = 11;
  localparam int unsigned POS_FIELD_C   = 16;
  localparam int unsigned W_REG         = 5;
  localparam int unsigned W_CFIELD      = 3;
  localparam int unsigned POS_CMASK     = 12;
  localparam int unsigned W_CMASK       = 8;
  localparam int unsigned POS_SPLIT     = 11;
  localparam int unsigned W_SPLIT       = 10;
  localparam int unsigned POS_EXT_EN    = 16;
  localparam int unsigned POS_MBEGIN    = 21;
  localparam int unsigned POS_MEND      = 26;
  localparam int unsigned POS_LONG_DISP = 6;
  localparam int unsigned W_LONG_DISP   = 24;
  localparam int unsigned POS_COND_DISP = 16;
  localparam int unsigned W_COND_DISP   = 14;
  localparam int unsigned POS_IMM       = 16;
  localparam int unsigned W_IMM         = 16;
  localparam int unsigned W_PAD         = 2;
  localparam int unsigned FLAGS_PER_FLD = 4;

  localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;

  // instruction fields, registered toward execute and register file
  typedef struct packed {
    logic [5:0]  primary_opcode;
    logic [9:0]  secondary_opcode;
    logic        overflow_update_en;
    logic        record_bit;
    logic        link_bit;
    logic        absolute_addr_bit;
    logic [4:0]  target_reg_sel;
    logic [4:0]  store_src_reg_sel;
    logic [4:0]  first_reg_sel;
    logic [4:0]  second_reg_sel;
    logic [4:0]  cond_bit_src_b;
    logic [4:0]  cond_bit_dest;
    logic [2:0]  cond_field_dest;
    logic [2:0]  cond_field_src;
    logic [7:0]  cond_field_mask;
    logic [9:0]  devreg_num;
    logic [9:0]  special_reg_num;
    logic [9:0]  timebase_num;
    logic        ext_interrupt_enable;
    logic [4:0]  mask_begin;
    logic [4:0]  mask_end;
    logic [4:0]  string_byte_count;
    logic [4:0]  rotate_count;
    logic [4:0]  trap_condition_sel;
    logic [31:0] signed_immediate;
    logic [31:0] unsigned_immediate;
    logic [31:0] load_store_disp;
  } ife_fields_s;

  // branch displacements and resolved targets
  typedef struct packed {
    logic [31:0] long_branch_disp;
    logic [31:0] cond_branch_disp;
    logic [31:0] long_target;
    logic [31:0] cond_target;
  } ife_branch_s;

  // fetch-side request
  typedef struct packed {
    logic        valid;
    logic        ovf_form;
    logic [31:0] instr_addr;
    logic [31:0] instr;
  } ife_req_s;

endpackage
`default_nettype wire

// ==== verilog/ife_split_join.sv ====
// module: rejoins a split ten-bit register number field
`timescale 1ns/1ps
`default_nettype none
module ife_split_join
(
  input  wire logic [9:0] split_field,
  output logic      [9:0] joined_num
);

  // low half of the field holds the high half of the number
  // swap split halves
  always_comb
  begin
    joined_num = {split_field[4:0], split_field[9:5]};
  end

endmodule
`default_nettype wire

// ==== verilog/ife_field_extractor.sv ====
// module: registered field extractor for 32-bit instruction words
`timescale 1ns/1ps
`default_nettype none
module ife_field_extractor
(
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire ife_pkg::ife_req_s   req,
  input  wire logic                imm_is_unsigned,
  output logic                     out_valid,
  output ife_pkg::ife_fields_s     fields,
  output ife_pkg::ife_branch_s     branch,
  output logic [31:0]              cond_flags_we,
  output logic [31:0]              rotate_mask
);

  // big-endian bit b of the word sits at little-endian index 31-b
  // big-endian numbering
  function automatic logic [31:0] be_field(input logic [31:0] w,
                                           input int unsigned first,
                                           input int unsigned width);
    logic [31:0] sh;
    logic [31:0] msk;
    sh  = w >> (32 - first - width);
    msk = (width >= 32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << width) - 32'h0000_0001);
    return sh & msk;
  endfunction

  function automatic logic be_bit(input logic [31:0] w, input int unsigned pos);
    return w[31-pos];
  endfunction

  // sign extension of a narrow value held in the low bits
  function automatic logic [31:0] sext(input logic [31:0] v, input int unsigned width);
    logic [31:0] fill;
    fill = (width >= 32) ? 32'h0000_0000 : (32'hFFFF_FFFF << width);
    return v[width-1] ? (v | fill) : v;
  endfunction

  logic [31:0]          word;
  logic [31:0]          addr;
  logic [9:0]           split_raw;
  logic [9:0]           split_num;
  ife_pkg::ife_fields_s fld_now;
  ife_pkg::ife_branch_s br_now;
  logic [31:0]          long_raw;
  logic [31:0]          cond_raw;
  logic [31:0]          imm_raw;
  logic [31:0]          we_now;
  logic [31:0]          mask_now;

  ife_pkg::ife_fields_s fields_reg;
  ife_pkg::ife_fields_s fields_next;
  ife_pkg::ife_branch_s branch_reg;
  ife_pkg::ife_branch_s branch_next;
  logic [31:0]          cond_flags_we_reg;
  logic [31:0]          cond_flags_we_next;
  logic [31:0]          rotate_mask_reg;
  logic [31:0]          rotate_mask_next;
  logic                 out_valid_reg;
  logic                 out_valid_next;

  assign word = req.instr;
  assign addr = req.instr_addr;
  assign split_raw = 10'(be_field(word, ife_pkg::POS_SPLIT, ife_pkg::W_SPLIT));

  ife_split_join u_split_join
  (
    .split_field (split_raw),
    .joined_num  (split_num)
  );

  // field separation
  always_comb
  begin
    fld_now = '0;
    fld_now.primary_opcode = 6'(be_field(word, ife_pkg::POS_PRIMARY, ife_pkg::W_PRIMARY));
    if (req.ovf_form)
    begin
      fld_now.secondary_opcode = 10'(be_field(word, ife_pkg::POS_SEC_OVF, ife_pkg::W_SEC_OVF));
    end
    else
    begin
      fld_now.secondary_opcode = 10'(be_field(word, ife_pkg::POS_SEC_PLAIN, ife_pkg::W_SEC_PLAIN));
    end
    fld_now.overflow_update_en = req.ovf_form & be_bit(word, ife_pkg::POS_OVF_EN);
    fld_now.record_bit = be_bit(word, ife_pkg::POS_RECORD);
    fld_now.link_bit = be_bit(word, ife_pkg::POS_LINK);
    fld_now.absolute_addr_bit = be_bit(word, ife_pkg::POS_ABS);
    fld_now.target_reg_sel    = 5'(be_field(word, ife_pkg::POS_FIELD_A, ife_pkg::W_REG));
    fld_now.store_src_reg_sel = 5'(be_field(word, ife_pkg::POS_FIELD_A, ife_pkg::W_REG));
    fld_now.first_reg_sel  = 5'(be_field(word, ife_pkg::POS_FIELD_B, ife_pkg::W_REG));
    fld_now.second_reg_sel = 5'(be_field(word, ife_pkg::POS_FIELD_C, ife_pkg::W_REG));
    fld_now.cond_bit_src_b = 5'(be_field(word, ife_pkg::POS_FIELD_C, ife_pkg::W_REG));
    fld_now.cond_bit_dest  = 5'(be_field(word, ife_pkg::POS_FIELD_A, ife_pkg::W_REG));
    fld_now.cond_field_dest = 3'(be_field(word, ife_pkg::POS_FIELD_A, ife_pkg::W_CFIELD));
    fld_now.cond_field_src  = 3'(be_field(word, ife_pkg::POS_FIELD_B, ife_pkg::W_CFIELD));
    fld_now.cond_field_mask = 8'(be_field(word, ife_pkg::POS_CMASK, ife_pkg::W_CMASK));
    fld_now.devreg_num      = split_num;
    fld_now.special_reg_num = split_num;
    fld_now.timebase_num    = split_num;
    fld_now.ext_interrupt_enable = be_bit(word, ife_pkg::POS_EXT_EN);
    fld_now.mask_begin = 5'(be_field(word, ife_pkg::POS_MBEGIN, ife_pkg::W_REG));
    fld_now.mask_end   = 5'(be_field(word, ife_pkg::POS_MEND, ife_pkg::W_REG));
    fld_now.string_byte_count = 5'(be_field(word, ife_pkg::POS_FIELD_C, ife_pkg::W_REG));
    fld_now.rotate_count = 5'(be_field(word, ife_pkg::POS_FIELD_C, ife_pkg::W_REG));
    fld_now.trap_condition_sel = 5'(be_field(word, ife_pkg::POS_FIELD_A, ife_pkg::W_REG));
    fld_now.unsigned_immediate = imm_raw;
    if (imm_is_unsigned)
    begin
      fld_now.signed_immediate = imm_raw;
    end
    else
    begin
      fld_now.signed_immediate = sext(imm_raw, ife_pkg::W_IMM);
    end
    fld_now.load_store_disp = sext(imm_raw, ife_pkg::W_IMM);
  end

  assign imm_raw = be_field(word, ife_pkg::POS_IMM, ife_pkg::W_IMM);

  // branch displacements and targets
  always_comb
  begin
    long_raw = be_field(word, ife_pkg::POS_LONG_DISP, ife_pkg::W_LONG_DISP) << ife_pkg::W_PAD;
    cond_raw = be_field(word, ife_pkg::POS_COND_DISP, ife_pkg::W_COND_DISP) << ife_pkg::W_PAD;
    br_now.long_branch_disp = sext(long_raw, ife_pkg::W_LONG_DISP + ife_pkg::W_PAD);
    br_now.cond_branch_disp = sext(cond_raw, ife_pkg::W_COND_DISP + ife_pkg::W_PAD);
    if (be_bit(word, ife_pkg::POS_ABS))
    begin
      br_now.long_target = br_now.long_branch_disp;
      br_now.cond_target = br_now.cond_branch_disp;
    end
    else
    begin
      br_now.long_target = br_now.long_branch_disp + addr;
      br_now.cond_target = br_now.cond_branch_disp + addr;
    end
  end

  // per-flag write enables and rotate mask, index is big-endian position
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1)
    begin : g_bits
      assign we_now[31-gi] = fld_now.cond_field_mask[7 - (gi / ife_pkg::FLAGS_PER_FLD)];
      // mask from begin to end, wrapping
      assign mask_now[31-gi] = (fld_now.mask_begin <= fld_now.mask_end)
                             ? ((5'(gi) >= fld_now.mask_begin) && (5'(gi) <= fld_now.mask_end))
                             : ((5'(gi) >= fld_now.mask_begin) || (5'(gi) <= fld_now.mask_end));
    end
  endgenerate

  // next values: capture on a valid word, hold otherwise; out_valid follows req.valid every cycle outside reset
  always_comb
  begin
    out_valid_next     = req.valid;
    fields_next        = fields_reg;
    branch_next        = branch_reg;
    cond_flags_we_next = cond_flags_we_reg;
    rotate_mask_next   = rotate_mask_reg;
    if (req.valid)
    begin
      fields_next        = fld_now;
      branch_next        = br_now;
      cond_flags_we_next = we_now;
      rotate_mask_next   = mask_now;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      out_valid_reg     <= 1'b0;
      fields_reg        <= '0;
      branch_reg        <= '0;
      cond_flags_we_reg <= ife_pkg::WORD_RESET;
      rotate_mask_reg   <= ife_pkg::WORD_RESET;
    end
    else
    begin
      out_valid_reg     <= out_valid_next;
      fields_reg        <= fields_next;
      branch_reg        <= branch_next;
      cond_flags_we_reg <= cond_flags_we_next;
      rotate_mask_reg   <= rotate_mask_next;
    end
  end

  assign out_valid     = out_valid_reg;
  assign fields        = fields_reg;
  assign branch        = branch_reg;
  assign cond_flags_we = cond_flags_we_reg;
  assign rotate_mask   = rotate_mask_reg;

endmodule
`default_nettype wire

// ==== dv/ife_field_extractor_monitor.sv ====
// checker: port-level properties of the instruction field extractor
`timescale 1ns/1ps
`default_nettype none
module ife_field_extractor_monitor
(
  input wire logic                 sys_clk,
  input wire logic                 rst,
  input wire ife_pkg::ife_req_s    req,
  input wire logic                 imm_is_unsigned,
  input wire logic                 out_valid,
  input wire ife_pkg::ife_fields_s fields,
  input wire ife_pkg::ife_branch_s branch,
  input wire logic [31:0]          cond_flags_we,
  input wire logic [31:0]          rotate_mask
);
  ife_pkg::ife_req_s q_reg;
  ife_pkg::ife_req_s q_next;
  logic              u_reg;
  logic              u_next;
  logic [31:0]       w;
  logic [31:0]       ld;
  logic [31:0]       cd;
  logic [31:0]       fm;
  logic [31:0]       rm;
  always_comb
  begin
    q_next = req.valid ? req : q_reg;
    u_next = req.valid ? imm_is_unsigned : u_reg;
    w = q_reg.instr;
    ld = {{6{w[25]}}, w[25:2], 2'b00};
    cd = {{16{w[15]}}, w[15:2], 2'b00};
    for (int k = 0; k < 8; k++)
      fm[31-4*k -: 4] = {4{w[19-k]}};
    for (int p = 0; p < 32; p++)
      rm[31-p] = (w[10:6] <= w[5:1]) ? (p >= w[10:6] && p <= w[5:1]) : (p >= w[10:6] || p <= w[5:1]);
  end
  always_ff @(posedge sys_clk)
  begin
    q_reg <= q_next;
    u_reg <= u_next;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_take; req.valid ##1 out_valid; endsequence
  property p_latency; req.valid |=> out_valid; endproperty
  property p_idle; !req.valid |=> !out_valid; endproperty
  property p_opcode; s_take |-> fields.primary_opcode == w[31:26]; endproperty
  property p_secondary; s_take |-> fields.overflow_update_en == (q_reg.ovf_form & w[10])
    && fields.secondary_opcode == (q_reg.ovf_form ? {1'b0, w[9:1]} : w[10:1]); endproperty
  property p_bit31; s_take |-> fields.record_bit == w[0] && fields.link_bit == w[0]; endproperty
  property p_regs; s_take |-> {fields.target_reg_sel, fields.store_src_reg_sel, fields.first_reg_sel,
    fields.second_reg_sel, fields.trap_condition_sel} == {w[25:21], w[25:21], w[20:16], w[15:11], w[25:21]};
  endproperty
  property p_cond; s_take |-> {fields.cond_bit_src_b, fields.cond_bit_dest, fields.cond_field_dest,
    fields.cond_field_src, fields.cond_field_mask} == {w[15:11], w[25:21], w[25:23], w[20:18], w[19:12]}
    && cond_flags_we == fm; endproperty
  property p_split; s_take |-> {fields.devreg_num, fields.special_reg_num, fields.timebase_num}
    == {3{w[15:11], w[20:16]}}; endproperty
  property p_imm; s_take |-> fields.load_store_disp == {{16{w[15]}}, w[15:0]}
    && fields.signed_immediate == {u_reg ? 16'h0000 : {16{w[15]}}, w[15:0]}
    && fields.unsigned_immediate == {16'h0000, w[15:0]}; endproperty
  property p_disp; s_take |-> branch.long_branch_disp == ld && branch.cond_branch_disp == cd; endproperty
  property p_target; s_take |-> branch.long_target == (w[1] ? ld : ld + q_reg.instr_addr)
    && branch.cond_target == (w[1] ? cd : cd + q_reg.instr_addr); endproperty
  property p_mask; s_take |-> {fields.mask_begin, fields.mask_end, fields.string_byte_count, fields.rotate_count,
    fields.ext_interrupt_enable} == {w[10:6], w[5:1], w[15:11], w[15:11], w[15]} && rotate_mask == rm; endproperty
  a_latency: assert property (p_latency) else $error("output valid missing");
  a_idle: assert property (p_idle) else $error("output valid without word");
  a_opcode: assert property (p_opcode) else $error("primary opcode wrong");
  a_secondary: assert property (p_secondary) else $error("secondary opcode wrong");
  a_bit31: assert property (p_bit31) else $error("record or link bit wrong");
  a_regs: assert property (p_regs) else $error("register selects wrong");
  a_cond: assert property (p_cond) else $error("condition selects wrong");
  a_split: assert property (p_split) else $error("split number wrong");
  a_imm: assert property (p_imm) else $error("immediate wrong");
  a_disp: assert property (p_disp) else $error("branch displacement wrong");
  a_target: assert property (p_target) else $error("branch target wrong");
  a_mask: assert property (p_mask) else $error("mask or count fields wrong");
endmodule
bind ife_field_extractor ife_field_extractor_monitor u_mon (.sys_clk(sys_clk), .rst(rst), .req(req),
  .imm_is_unsigned(imm_is_unsigned), .out_valid(out_valid), .fields(fields), .branch(branch),
  .cond_flags_we(cond_flags_we), .rotate_mask(rotate_mask));
`default_nettype wire

// ==== dv/ife_fetch_model.sv ====
// model: fetch stage presenting instruction words
`timescale 1ns/1ps
`default_nettype none
module ife_fetch_model
(
  input  wire logic        sys_clk,
  input  wire logic        push,
  input  wire logic        ovf,
  input  wire logic [31:0] word,
  input  wire logic [31:0] addr,
  output ife_pkg::ife_req_s req
);
  logic [31:0] last_word;
  initial last_word = 32'h0000_0000;
  always @(posedge sys_clk)
    if (push)
      last_word <= word;
  // idle bus shows inverted data, never the old word
  always_comb
  begin
    req.valid = push;
    req.ovf_form = push ? ovf : ~ovf;
    req.instr = push ? word : ~last_word;
    req.instr_addr = push ? addr : ~addr;
  end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// testbench: instruction words in, extracted fields checked
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                 sys_clk;
  logic                 rst;
  logic                 push;
  logic                 ovf;
  logic                 uns;
  logic [31:0]          word;
  logic [31:0]          addr;
  logic                 out_valid;
  logic [31:0]          cfw;
  logic [31:0]          rmask;
  ife_pkg::ife_req_s    req;
  ife_pkg::ife_fields_s f;
  ife_pkg::ife_branch_s b;
  int                   miscompares;
  int                   checked;
  ife_fetch_model model (.sys_clk(sys_clk), .push(push), .ovf(ovf), .word(word), .addr(addr), .req(req));
  ife_field_extractor dut (.sys_clk(sys_clk), .rst(rst), .req(req), .imm_is_unsigned(uns),
    .out_valid(out_valid), .fields(f), .branch(b), .cond_flags_we(cfw), .rotate_mask(rmask));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic send(input logic [31:0] w, input logic [31:0] a, input logic o, input logic u);
    int n;
    n = 0;
    @(negedge sys_clk);
    push = 1'b1;
    word = w;
    addr = a;
    ovf = o;
    uns = u;
    @(negedge sys_clk);
    push = 1'b0;
    while (out_valid !== 1'b1 && n < 8)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk("out_valid", 32'h1, 32'(out_valid));
    if (n == 8)
      summarize();
  endtask
  task automatic t_fields();
    send(32'h7C8A_B5E7, 32'h0, 1'b0, 1'b0);
    chk("regs", 32'h1156, 32'({f.target_reg_sel, f.first_reg_sel, f.second_reg_sel}));
    chk("trap", 32'h04, 32'(f.trap_condition_sel));
    chk("split", 32'h2CA, 32'(f.special_reg_num));
    chk("cfields", 32'h0A, 32'({f.cond_field_dest, f.cond_field_src}));
    chk("counts", 32'h2D6, 32'({f.string_byte_count, f.rotate_count}));
    chk("record", 32'h1, 32'(f.record_bit));
    chk("ext_en", 32'h1, 32'(f.ext_interrupt_enable));
    chk("flags_we", 32'hF0F0_F0FF, cfw);
    chk("rot_wrap", 32'hFFFF_F1FF, rmask);
    send(32'h5400_00F8, 32'h0, 1'b0, 1'b0);
    chk("rot_plain", 32'h1FFF_FFF8, rmask);
    $display("test fields done");
  endtask
  task automatic t_ovf();
    send(32'h7C64_2615, 32'h0, 1'b1, 1'b0);
    chk("sec_ovf", 32'h215, 32'({f.secondary_opcode, f.overflow_update_en}));
    send(32'h7C64_2615, 32'h0, 1'b0, 1'b0);
    chk("sec_plain", 32'h614, 32'({f.secondary_opcode, f.overflow_update_en}));
    $display("test ovf done");
  endtask
  task automatic t_branch();
    send(32'h4BFF_FFFC, 32'h0000_1000, 1'b0, 1'b0);
    chk("long_disp", 32'hFFFF_FFFC, b.long_branch_disp);
    chk("long_rel", 32'h0000_0FFC, b.long_target);
    send(32'h4800_0102, 32'h0000_1000, 1'b0, 1'b0);
    chk("long_abs", 32'h0000_0100, b.long_target);
    send(32'h4282_FFF9, 32'hFFFF_FFF0, 1'b0, 1'b0);
    chk("cond_disp", 32'hFFFF_FFF8, b.cond_branch_disp);
    chk("cond_rel", 32'hFFFF_FFE8, b.cond_target);
    chk("link", 32'h1, 32'(f.link_bit));
    $display("test branch done");
  endtask
  task automatic t_imm();
    send(32'h6000_8001, 32'h0, 1'b0, 1'b1);
    chk("imm_uns", 32'h0000_8001, f.signed_immediate);
    chk("disp", 32'hFFFF_8001, f.load_store_disp);
    send(32'h6000_8001, 32'h0, 1'b0, 1'b0);
    chk("imm_sgn", 32'hFFFF_8001, f.signed_immediate);
    chk("imm_zext", 32'h0000_8001, f.unsigned_immediate);
    $display("test imm done");
  endtask
  task automatic t_b2b();
    @(negedge sys_clk);
    push = 1'b1;
    word = 32'h1111_2222;
    @(negedge sys_clk);
    word = 32'hE8C3_0000;
    chk("opc_a", 32'h04, 32'(f.primary_opcode));
    chk("valid_a", 32'h1, 32'(out_valid));
    @(negedge sys_clk);
    push = 1'b0;
    chk("opc_b", 32'h3A, 32'(f.primary_opcode));
    chk("valid_b", 32'h1, 32'(out_valid));
    @(negedge sys_clk);
    chk("valid_end", 32'h0, 32'(out_valid));
    chk("opc_hold", 32'h3A, 32'(f.primary_opcode));
    $display("test b2b done");
  endtask
  task automatic t_reset();
    @(negedge sys_clk);
    push = 1'b1;
    word = 32'hFFFF_FFFF;
    rst = 1'b1;
    @(negedge sys_clk);
    push = 1'b0;
    @(negedge sys_clk);
    rst = 1'b0;
    chk("rst_valid", 32'h0, 32'(out_valid));
    chk("rst_imm", 32'h0, f.signed_immediate);
    send(32'h1111_2222, 32'h0, 1'b0, 1'b0);
    chk("post_rst_opc", 32'h04, 32'(f.primary_opcode));
    $display("test reset done");
  endtask
  initial
  begin
    rst = 1'b1;
    push = 1'b0;
    ovf = 1'b0;
    uns = 1'b0;
    word = 32'h0;
    addr = 32'h0;
    miscompares = 0;
    checked = 0;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    t_fields();
    t_ovf();
    t_branch();
    t_imm();
    t_b2b();
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire
